// [tap_bist_defines.vh]
// constants for the test access port and memory self-test sequencer
// assumes inclusion by bare name from the design files
`ifndef TAP_BIST_DEFINES_VH
`define TAP_BIST_DEFINES_VH
`define IR_W 4
`define OP_EXTEST 4'h0
`define OP_SAMPLE 4'h1
`define OP_RESULT_SCAN 4'h2
`define OP_MODE_SCAN 4'h3
`define OP_CLAMP 4'h5
`define OP_FLOAT 4'h6
`define OP_IDENT 4'h7
`define OP_RUN_BIST 4'h8
`define OP_BYPASS 4'hF
`define ID_W 32
`define BSR_W 392
`define RES_W 25
`define PKT_W 100
`define MODE_W 2
`define MODE_GONOGO 2'h0
`define MODE_DEBUG 2'h1
`define PKT_DONE_BIT 2
`define ST_W 6
`define ST_MOVI_ZEROS 6'h01
`define ST_MOVI_1_UP 6'h03
`define ST_MOVI_0_UP 6'h02
`define ST_MOVI_1_DN 6'h06
`define ST_MOVI_0_DN 6'h07
`define ST_MOVI_READ 6'h05
`define ST_MARCH_FILL_ZERO_STATE 6'h04
`define ST_MAR2_1_UP 6'h0C
`define ST_MAR2_0_UP 6'h0D
`define ST_MAR2_1_DN 6'h0F
`define ST_MAR2_0_DN 6'h0E
`define ST_MARCH_FINAL_READ_STATE 6'h0A
`define ST_CHKR_W 6'h0B
`define ST_CHKR_R 6'h09
`define ST_NCHKR_W 6'h08
`define ST_NCHKR_R 6'h18
`define ST_UA_ZEROS 6'h19
`define ST_UA_WRITE 6'h1B
`define ST_UA_READ 6'h1A
`define ST_UA_ONES 6'h1E
`define ST_UA_NWRITE 6'h1F
`define ST_UA_NREAD 6'h1D
`define ST_COMPLETE 6'h32
`define ADDR_W 16
`endif

// [bist_sequencer.v]
// memory self-test sequencer: walks the algorithm states over the address space
// assumes self_test_clock already sampled into mclk domain as a one-cycle step pulse
`timescale 1ns/1ps
`include "tap_bist_defines.vh"
module bist_sequencer (
  input wire mclk, // system clock
  input wire sys_rst, // synchronous reset
  input wire start, // one-cycle start pulse
  input wire step, // one memory operation slot per pulse
  output reg [5:0] state_r, // current state code
  output reg [15:0] addr_r, // current address
  output reg [1:0] writer_r, // writing port minus one
  output reg busy_r, // sequence running
  output reg done_r // completion reached
);
  reg [1:0] phase_r; // sub-step: read, write, read
  reg [5:0] state_nxt; // next state code
  reg [1:0] writer_nxt; // next writer
  wire down; // descending address order
  wire three_op; // read-write-read element
  // descending passes; also picks the start address of the next state
  function is_down;
    input [5:0] s;
    begin
      is_down = (s == `ST_MOVI_1_DN) || (s == `ST_MOVI_0_DN) ||
                (s == `ST_MAR2_1_DN) || (s == `ST_MAR2_0_DN);
    end
  endfunction
  assign down = is_down(state_r);
  assign three_op = (state_r == `ST_MOVI_1_UP) || (state_r == `ST_MOVI_0_UP) || down ||
                    (state_r == `ST_MAR2_1_UP) || (state_r == `ST_MAR2_0_UP);
  // successor of each state; unique-address steps loop over ports 2..4
  always @*
  begin
    state_nxt = state_r;
    writer_nxt = writer_r;
    case (state_r)
      `ST_MOVI_ZEROS: state_nxt = `ST_MOVI_1_UP;
      `ST_MOVI_1_UP: state_nxt = `ST_MOVI_0_UP;
      `ST_MOVI_0_UP: state_nxt = `ST_MOVI_1_DN;
      `ST_MOVI_1_DN: state_nxt = `ST_MOVI_0_DN;
      `ST_MOVI_0_DN: state_nxt = `ST_MOVI_READ;
      `ST_MOVI_READ: state_nxt = `ST_MARCH_FILL_ZERO_STATE;
      `ST_MARCH_FILL_ZERO_STATE: state_nxt = `ST_MAR2_1_UP;
      `ST_MAR2_1_UP: state_nxt = `ST_MAR2_0_UP;
      `ST_MAR2_0_UP: state_nxt = `ST_MAR2_1_DN;
      `ST_MAR2_1_DN: state_nxt = `ST_MAR2_0_DN;
      `ST_MAR2_0_DN: state_nxt = `ST_MARCH_FINAL_READ_STATE;
      `ST_MARCH_FINAL_READ_STATE: state_nxt = `ST_CHKR_W;
      `ST_CHKR_W: state_nxt = `ST_CHKR_R;
      `ST_CHKR_R: state_nxt = `ST_NCHKR_W;
      `ST_NCHKR_W: state_nxt = `ST_NCHKR_R;
      `ST_NCHKR_R:
      begin
        state_nxt = `ST_UA_ZEROS;
        writer_nxt = 2'h1;
      end
      `ST_UA_ZEROS: state_nxt = `ST_UA_WRITE;
      `ST_UA_WRITE: state_nxt = `ST_UA_READ;
      `ST_UA_READ: state_nxt = `ST_UA_ONES;
      `ST_UA_ONES: state_nxt = `ST_UA_NWRITE;
      `ST_UA_NWRITE: state_nxt = `ST_UA_NREAD;
      `ST_UA_NREAD:
      begin
        // same codes repeat for ports 3 and 4, then completion
        if (writer_r == 2'h3)
          state_nxt = `ST_COMPLETE;
        else
        begin
          state_nxt = `ST_UA_ZEROS;
          writer_nxt = writer_r + 2'h1;
        end
      end
      default: state_nxt = `ST_COMPLETE;
    endcase
  end
  // one step per address, three in read-write-read states; a state ends after the last address
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      state_r <= `ST_MOVI_ZEROS;
      addr_r <= 16'h0000;
      writer_r <= 2'h0;
      phase_r <= 2'h0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end
    else if (start)
    begin
      state_r <= `ST_MOVI_ZEROS;
      addr_r <= 16'h0000;
      writer_r <= 2'h0;
      phase_r <= 2'h0;
      busy_r <= 1'b1;
      done_r <= 1'b0;
    end
    else if (busy_r && step)
    begin
      if (three_op && phase_r != 2'h2)
        phase_r <= phase_r + 2'h1; // read, write, read at one address
      else
      begin
        phase_r <= 2'h0;
        if (addr_r == (down ? 16'h0000 : 16'hFFFF))
        begin
          state_r <= state_nxt;
          writer_r <= writer_nxt;
          // every downward pass must begin at the top, or it ends after one address
          addr_r <= is_down(state_nxt) ? 16'hFFFF : 16'h0000;
          if (state_nxt == `ST_COMPLETE)
          begin
            busy_r <= 1'b0; // extra clocks after this change nothing
            done_r <= 1'b1;
          end
        end
        else
          addr_r <= down ? addr_r - 16'h0001 : addr_r + 16'h0001;
      end
    end
  end
endmodule // bist_sequencer

// [jtag_tap_mbist_controller.v]
// test access port: state machine, instruction decode, scan registers, self-test glue
// assumes tck, tms, tdi, self_test_clock arrive asynchronously and are sampled on mclk
`timescale 1ns/1ps
`include "tap_bist_defines.vh"
// Notes on behaviour
// - code 0111 selects loaded 32-bit identification register
// - identity fields version, part, vendor fixed
// - identification bit zero always reads one
// - code 0000 captures pins, selects 392-bit ring
// - code 0001 captures pins, selects boundary ring
// - code 1111 selects 1-bit bypass register
// - code 0110 bypass path, all outputs floated
// - code 0101 drives held boundary values, bypass
// - code 1000 starts self-test, 100-bit packet
// - code 0010 selects 25-bit result register
// - code 0011 selects 2-bit mode register
// - mode 00 go/no-go, 01 debug
// - sequencer starts at 000001, port 1 zeros
// - 000011 ascends, read0 write1 read1
// - then 000010, 000110, 000111, 000101
// - march states 000100 through 001010 in order
// - checkerboard 001011, 001001, 001000, 011000
// - unique-address six steps for port 2
// - repeat for ports 3, 4; then 110010
// - result bit zero is fail flag
// - mode register resets to 00
// - identification instruction loaded at test-logic-reset
// - packet bit 2 is test-done flag
module jtag_tap_mbist_controller (
  input wire mclk, // system clock, 100 MHz
  input wire sys_rst, // synchronous reset, active high
  input wire tck, // test clock pin
  input wire tms, // mode select pin
  input wire tdi, // serial data in pin
  input wire self_test_clock, // self-test clock pin
  input wire [391:0] pin_ring, // sampled pin states for capture
  input wire [71:0] cmp_fail, // per-bit comparator fails, four ports
  input wire cmp_valid, // comparator result valid this cycle
  output reg tdo, // serial data out
  output reg tdo_en_n, // low while tdo is driven
  output reg [391:0] bsr_hold_r, // boundary update stage
  output wire bsr_drive, // outputs follow boundary hold
  output wire float_outputs, // force functional outputs high-z
  output wire [5:0] bist_state, // sequencer state code
  output wire [15:0] bist_addr, // sequencer address
  output wire [1:0] bist_writer // writing port minus one
);
  parameter [3:0] ID_VERSION = 4'h2; // arbitrary identity value
  parameter [15:0] ID_PART = 16'h1234; // arbitrary identity value
  parameter [10:0] ID_VENDOR = 11'h055; // arbitrary identity value
  localparam [3:0] S_RESET = 4'h0, S_IDLE = 4'h1, S_SEL_DR = 4'h2, S_CAP_DR = 4'h3;
  localparam [3:0] S_SH_DR = 4'h4, S_EX1_DR = 4'h5, S_PA_DR = 4'h6, S_EX2_DR = 4'h7;
  localparam [3:0] S_UP_DR = 4'h8, S_SEL_IR = 4'h9, S_CAP_IR = 4'hA, S_SH_IR = 4'hB;
  localparam [3:0] S_EX1_IR = 4'hC, S_PA_IR = 4'hD, S_EX2_IR = 4'hE, S_UP_IR = 4'hF;
  // register-path selector
  localparam [2:0] P_BYP = 3'h0, P_ID = 3'h1, P_BSR = 3'h2, P_RES = 3'h3;
  localparam [2:0] P_MODE = 3'h4, P_PKT = 3'h5;

  // map instruction to serial path; reserved codes fall to bypass
  function [2:0] path_of;
    input [3:0] op;
    begin
      case (op)
        `OP_IDENT: path_of = P_ID;
        `OP_EXTEST: path_of = P_BSR;
        `OP_SAMPLE: path_of = P_BSR;
        `OP_RUN_BIST: path_of = P_PKT;
        `OP_RESULT_SCAN: path_of = P_RES;
        `OP_MODE_SCAN: path_of = P_MODE;
        default: path_of = P_BYP; // bypass, float, clamp and reserved
      endcase
    end
  endfunction

  reg [2:0] tck_s_r; // tck synchroniser plus history
  reg [1:0] tms_s_r; // tms synchroniser
  reg [1:0] tdi_s_r; // tdi synchroniser
  reg [2:0] stc_s_r; // self-test clock synchroniser plus history
  wire tck_rise; // test clock rising edge
  wire tck_fall; // test clock falling edge
  wire stc_rise; // self-test clock rising edge
  reg [3:0] tap_r; // tap state
  reg [3:0] tap_nxt; // next tap state
  reg [3:0] ir_r; // instruction register
  reg [3:0] ir_sh_r; // instruction shift stage
  reg byp_r; // bypass register
  reg [31:0] id_sh_r; // identification shift stage
  reg [391:0] bsr_sh_r; // boundary shift stage
  reg [24:0] res_r; // result register
  reg [24:0] res_sh_r; // result shift stage
  reg [1:0] mode_r; // bist mode register
  reg [1:0] mode_sh_r; // mode shift stage
  reg [99:0] pkt_r; // latest failure packet
  reg [99:0] pkt_sh_r; // packet shift stage
  reg [15:0] skip_r; // failures already reported since reset; kept across runs
  reg [15:0] seen_r; // failures seen in this run
  reg start_r; // start pulse to sequencer
  reg armed_r; // self-test instruction awaiting idle
  wire seq_busy; // sequencer running
  wire seq_done; // sequencer finished
  wire [2:0] path; // current serial path
  wire scan_out; // bit presented to tdo
  wire fail_now; // a failing read this cycle
  wire [31:0] id_word; // identity constant

  assign path = path_of(ir_r);
  assign float_outputs = (ir_r == `OP_FLOAT);
  assign bsr_drive = (ir_r == `OP_EXTEST) || (ir_r == `OP_CLAMP);
  assign id_word = {ID_VERSION, ID_PART, ID_VENDOR, 1'b1};
  assign fail_now = cmp_valid && seq_busy && (|cmp_fail);

  // synchronisers; only the second stage onward is looked at
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      tck_s_r <= 3'h0;
      tms_s_r <= 2'h0;
      tdi_s_r <= 2'h0;
      stc_s_r <= 3'h0;
    end
    else
    begin
      tck_s_r <= {tck_s_r[1:0], tck};
      tms_s_r <= {tms_s_r[0], tms};
      tdi_s_r <= {tdi_s_r[0], tdi};
      stc_s_r <= {stc_s_r[1:0], self_test_clock};
    end
  end
  assign tck_rise = tck_s_r[1] && !tck_s_r[2];
  assign tck_fall = !tck_s_r[1] && tck_s_r[2];
  assign stc_rise = stc_s_r[1] && !stc_s_r[2];

  // standard sixteen-state tap walk on tms
  always @*
  begin
    case (tap_r)
      S_RESET: tap_nxt = tms_s_r[1] ? S_RESET : S_IDLE;
      S_IDLE: tap_nxt = tms_s_r[1] ? S_SEL_DR : S_IDLE;
      S_SEL_DR: tap_nxt = tms_s_r[1] ? S_SEL_IR : S_CAP_DR;
      S_CAP_DR: tap_nxt = tms_s_r[1] ? S_EX1_DR : S_SH_DR;
      S_SH_DR: tap_nxt = tms_s_r[1] ? S_EX1_DR : S_SH_DR;
      S_EX1_DR: tap_nxt = tms_s_r[1] ? S_UP_DR : S_PA_DR;
      S_PA_DR: tap_nxt = tms_s_r[1] ? S_EX2_DR : S_PA_DR;
      S_EX2_DR: tap_nxt = tms_s_r[1] ? S_UP_DR : S_SH_DR;
      S_UP_DR: tap_nxt = tms_s_r[1] ? S_SEL_DR : S_IDLE;
      S_SEL_IR: tap_nxt = tms_s_r[1] ? S_RESET : S_CAP_IR;
      S_CAP_IR: tap_nxt = tms_s_r[1] ? S_EX1_IR : S_SH_IR;
      S_SH_IR: tap_nxt = tms_s_r[1] ? S_EX1_IR : S_SH_IR;
      S_EX1_IR: tap_nxt = tms_s_r[1] ? S_UP_IR : S_PA_IR;
      S_PA_IR: tap_nxt = tms_s_r[1] ? S_EX2_IR : S_PA_IR;
      S_EX2_IR: tap_nxt = tms_s_r[1] ? S_UP_IR : S_SH_IR;
      S_UP_IR: tap_nxt = tms_s_r[1] ? S_SEL_DR : S_IDLE;
      default: tap_nxt = S_RESET;
    endcase
  end

  // tap state, instruction and shift stages advance on test clock rise
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      tap_r <= S_RESET;
      ir_r <= `OP_IDENT;
      ir_sh_r <= 4'h0;
      byp_r <= 1'b0;
      id_sh_r <= 32'h0;
      bsr_sh_r <= {392{1'b0}};
      bsr_hold_r <= {392{1'b0}};
      res_sh_r <= 25'h0;
      mode_r <= `MODE_GONOGO;
      mode_sh_r <= 2'h0;
      pkt_sh_r <= 100'h0;
      armed_r <= 1'b0;
      start_r <= 1'b0;
    end
    else
    begin
      start_r <= 1'b0;
      if (tck_rise)
      begin
        tap_r <= tap_nxt;
        case (tap_r)
          S_RESET: ir_r <= `OP_IDENT;
          S_IDLE:
          begin
            // test starts once idle is reached; a fresh load restarts a stalled run
            if (armed_r)
            begin
              start_r <= 1'b1;
              armed_r <= 1'b0;
            end
          end
          S_CAP_IR: ir_sh_r <= 4'h1;
          S_SH_IR: ir_sh_r <= {tdi_s_r[1], ir_sh_r[3:1]};
          S_UP_IR:
          begin
            ir_r <= ir_sh_r; // codes outside the nine defined act as bypass
            armed_r <= (ir_sh_r == `OP_RUN_BIST);
          end
          S_CAP_DR:
          begin
            byp_r <= 1'b0;
            id_sh_r <= id_word;
            if (path == P_BSR)
              bsr_sh_r <= pin_ring;
            res_sh_r <= res_r;
            mode_sh_r <= mode_r;
            pkt_sh_r <= pkt_r;
          end
          S_SH_DR:
          begin
            case (path)
              P_ID: id_sh_r <= {tdi_s_r[1], id_sh_r[31:1]};
              P_BSR: bsr_sh_r <= {tdi_s_r[1], bsr_sh_r[391:1]};
              P_RES: res_sh_r <= {tdi_s_r[1], res_sh_r[24:1]};
              P_MODE: mode_sh_r <= {tdi_s_r[1], mode_sh_r[1]};
              P_PKT: pkt_sh_r <= {tdi_s_r[1], pkt_sh_r[99:1]};
              default: byp_r <= tdi_s_r[1];
            endcase
          end
          S_UP_DR:
          begin
            if (path == P_BSR)
              bsr_hold_r <= bsr_sh_r;
            // reserved mode values are ignored, keeping the last legal mode
            if (path == P_MODE && !mode_sh_r[1])
              mode_r <= mode_sh_r;
          end
          default: ;
        endcase
      end
    end
  end

  // tdo changes only on the test clock's falling edge
  assign scan_out = (tap_r == S_SH_IR) ? ir_sh_r[0] :
                    (path == P_ID) ? id_sh_r[0] :
                    (path == P_BSR) ? bsr_sh_r[0] :
                    (path == P_RES) ? res_sh_r[0] :
                    (path == P_MODE) ? mode_sh_r[0] :
                    (path == P_PKT) ? pkt_sh_r[0] : byp_r;
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      tdo <= 1'b0;
      tdo_en_n <= 1'b1;
    end
    else if (tck_fall)
    begin
      tdo <= scan_out;
      tdo_en_n <= !((tap_r == S_SH_DR) || (tap_r == S_SH_IR));
    end
  end

  // result counting and debug packet capture
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      res_r <= 25'h0;
      pkt_r <= 100'h0;
      skip_r <= 16'h0;
      seen_r <= 16'h0;
    end
    else if (start_r)
    begin
      res_r <= 25'h0;
      seen_r <= 16'h0;
      // a fresh debug run marks not-done until the sequencer completes with no failure left unsent
      pkt_r <= 100'h0;
    end
    else
    begin
      if (fail_now)
      begin
        // count lives in bits 24:1, fail flag in bit 0
        res_r <= {res_r[24:1] + 24'h000001, 1'b1};
        seen_r <= seen_r + 16'h0001;
        // debug mode reports the first failure not yet shown and each later one; the packet keeps the last
        if (mode_r == `MODE_DEBUG && seen_r == skip_r)
        begin
          pkt_r <= {2'h3, cmp_fail, bist_addr, bist_state, 1'b0, 1'b0, 2'h3};
          skip_r <= skip_r + 16'h0001;
        end
      end
      if (seq_done && mode_r == `MODE_DEBUG && seen_r <= skip_r)
        pkt_r[`PKT_DONE_BIT] <= 1'b1; // last failure already sent
    end
  end

  bist_sequencer u_seq (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .start(start_r),
    .step(stc_rise),
    .state_r(bist_state),
    .addr_r(bist_addr),
    .writer_r(bist_writer),
    .busy_r(seq_busy),
    .done_r(seq_done)
  );
endmodule // jtag_tap_mbist_controller

// [tap_bist_props.sv]
// checker for the tap pins and the self-test sequencer outputs
// assumes binding to the top module, all in the mclk domain
`timescale 1ns/1ps
`include "tap_bist_defines.vh"
module tap_bist_props (
  input wire mclk, // system clock
  input wire sys_rst, // sync reset
  input wire tck, // test clock pin
  input wire tdo, // serial out
  input wire tdo_en_n, // low while tdo driven
  input wire bsr_drive, // boundary hold drives pins
  input wire float_outputs, // pins forced high-z
  input wire [5:0] bist_state, // state code
  input wire [15:0] bist_addr, // address
  input wire [1:0] bist_writer // writing port minus one
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  // reset reloads the ident code, so no pin control and no driving
  property p_rst_vals;
    $fell(sys_rst) |-> tdo_en_n && !float_outputs && !bsr_drive
      && bist_state == `ST_MOVI_ZEROS && bist_addr == 16'h0000;
  endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("reset state wrong");
  property p_excl;
    !(float_outputs && bsr_drive);
  endproperty
  a_excl: assert property (p_excl) else $error("float and drive together");
  // the synchroniser delay keeps tdo moves well inside the low phase
  property p_tdo_fall;
    $changed(tdo) |-> !tck && !$past(tck);
  endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("tdo moved off a fall");
  property p_en_fall;
    $changed(tdo_en_n) |-> !tck && !$past(tck);
  endproperty
  a_en_fall: assert property (p_en_fall) else $error("enable moved off a fall");
  // only the unique-address states and completion hand writing to another port
  property p_p1_writer;
    !(bist_state inside {`ST_UA_ZEROS, `ST_UA_WRITE, `ST_UA_READ, `ST_UA_ONES,
      `ST_UA_NWRITE, `ST_UA_NREAD, `ST_COMPLETE}) |-> bist_writer == 2'h0;
  endproperty
  a_p1_writer: assert property (p_p1_writer) else $error("wrong writer port");
  property p_zero_step;
    bist_state == `ST_MOVI_ZEROS && $past(bist_state) == `ST_MOVI_ZEROS
      && $changed(bist_addr) |-> bist_addr == $past(bist_addr) + 16'h0001
      || bist_addr == 16'h0000;
  endproperty
  a_zero_step: assert property (p_zero_step) else $error("fill address skipped");
  property p_up;
    bist_state == `ST_MOVI_1_UP && $past(bist_state) == `ST_MOVI_1_UP
      && $changed(bist_addr) |-> bist_addr == $past(bist_addr) + 16'h0001;
  endproperty
  a_up: assert property (p_up) else $error("upward pass skipped");
  property p_down;
    bist_state == `ST_MOVI_1_DN && $past(bist_state) == `ST_MOVI_1_DN
      && $changed(bist_addr) |-> bist_addr == $past(bist_addr) - 16'h0001;
  endproperty
  a_down: assert property (p_down) else $error("downward pass skipped");
  property p_ua_next;
    $changed(bist_state) && bist_state == `ST_UA_ZEROS |->
      $past(bist_state) inside {`ST_NCHKR_R, `ST_UA_NREAD}
      && bist_writer == $past(bist_writer) + 2'h1;
  endproperty
  a_ua_next: assert property (p_ua_next) else $error("bad writer handover");
  property p_complete;
    $changed(bist_state) && bist_state == `ST_COMPLETE |->
      $past(bist_state) == `ST_UA_NREAD && $past(bist_writer) == 2'h3;
  endproperty
  a_complete: assert property (p_complete) else $error("early completion");
  // extra clocks after completion must not move the sequencer
  property p_done;
    $changed(bist_state) && $past(bist_state) == `ST_COMPLETE |->
      bist_state == `ST_MOVI_ZEROS;
  endproperty
  a_done: assert property (p_done) else $error("left completion");
  c_fill: cover property (bist_state == `ST_MOVI_ZEROS && bist_addr == 16'h0010);
  c_drive: cover property (!tdo_en_n);
  c_float: cover property (float_outputs);
  c_hold: cover property (bsr_drive);
endmodule // tap_bist_props
bind jtag_tap_mbist_controller tap_bist_props u_tap_bist_props (
  .mclk(mclk), .sys_rst(sys_rst), .tck(tck), .tdo(tdo), .tdo_en_n(tdo_en_n),
  .bsr_drive(bsr_drive), .float_outputs(float_outputs), .bist_state(bist_state),
  .bist_addr(bist_addr), .bist_writer(bist_writer));

// [scan_host_model.sv]
// board test controller model: walks the tap and shifts frames
// assumes mclk from the bench; tck stands still between frames
`timescale 1ns/1ps
module scan_host_model (
  input wire mclk, // bench clock
  input wire tdo, // device serial out
  input wire tdo_en_n, // low while the device drives
  output reg tck, // test clock, 160 ns
  output reg tms, // mode select
  output reg tdi // serial in
);
  initial
  begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h0;
  end
  // one tck period, 8 mclk low then 8 high; tdo sampled before the rise
  task tick(input logic m, input logic d, output logic q);
  begin
    @(negedge mclk);
    tms = m;
    tdi = d;
    repeat (7) @(negedge mclk);
    // a released line reads as the inverted last bit, never as the last bit
    q = tdo_en_n ? ~tdo : tdo;
    tck = 1'h1;
    repeat (8) @(negedge mclk);
    tck = 1'h0;
  end
  endtask
  // five ones reach test-logic-reset, then settle in idle
  task tap_reset;
    logic q;
  begin
    repeat (5) tick(1'h1, 1'h0, q);
    tick(1'h0, 1'h0, q);
  end
  endtask
  // idle to idle frame, lsb first; ir selects the instruction path
  task shift(input logic ir, input int n, input logic [399:0] din,
    output logic [399:0] dout);
    logic q;
    int i;
  begin
    dout = {400{1'h0}};
    tick(1'h1, 1'h0, q);
    if (ir)
      tick(1'h1, 1'h0, q);
    tick(1'h0, 1'h0, q);
    tick(1'h0, 1'h0, q);
    for (i = 0; i < n; i++)
      tick(i == n - 1, din[i], dout[i]);
    tick(1'h1, 1'h0, q);
    tick(1'h0, 1'h0, q);
  end
  endtask
endmodule // scan_host_model

// [test_jtag_tap_mbist_controller.sv]
// self-checking bench for the tap and self-test sequencer
// assumes the host model drives tck, tms and tdi; the rest is driven here
`timescale 1ns/1ps
`include "tap_bist_defines.vh"
module test_jtag_tap_mbist_controller;
  localparam [3:0] T_VER = 4'h3; // arbitrary identity value
  localparam [15:0] T_PART = 16'h0ABC; // arbitrary identity value
  localparam [10:0] T_VEN = 11'h123; // arbitrary identity value
  logic mclk, sys_rst, tck, tms, tdi, self_test_clock, cmp_valid; // drives
  logic [391:0] pin_ring; // pin states
  logic [71:0] cmp_fail; // comparator fails
  logic tdo, tdo_en_n, bsr_drive, float_outputs; // observed
  logic [391:0] bsr_hold_r; // boundary hold
  logic [5:0] bist_state; // state code
  logic [15:0] bist_addr; // address
  logic [1:0] bist_writer; // writer
  logic [399:0] qv; // shifted-out frame
  int mismatches, n_checks, cycles;
  jtag_tap_mbist_controller #(.ID_VERSION(T_VER), .ID_PART(T_PART), .ID_VENDOR(T_VEN))
  u_jtag_tap_mbist_controller (.mclk(mclk), .sys_rst(sys_rst), .tck(tck), .tms(tms),
    .tdi(tdi), .self_test_clock(self_test_clock), .pin_ring(pin_ring),
    .cmp_fail(cmp_fail), .cmp_valid(cmp_valid), .tdo(tdo), .tdo_en_n(tdo_en_n),
    .bsr_hold_r(bsr_hold_r), .bsr_drive(bsr_drive), .float_outputs(float_outputs),
    .bist_state(bist_state), .bist_addr(bist_addr), .bist_writer(bist_writer));
  scan_host_model u_scan_host_model (.mclk(mclk), .tdo(tdo), .tdo_en_n(tdo_en_n),
    .tck(tck), .tms(tms), .tdi(tdi));
  initial
  begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  // hang guard; the whole run needs about 24k cycles
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 50000)
    begin
      mismatches++;
      end_sim;
    end
  end
  task chk(input string what, input logic [399:0] exp, input logic [399:0] got);
  begin
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  end
  endtask
  task end_sim;
  begin
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask
  // load an instruction; the capture pattern must read 0001
  task ir(input logic [3:0] code);
  begin
    u_scan_host_model.shift(1'h1, 4, {396'h0, code}, qv);
    chk("ir capture", 4'h1, qv[3:0]);
  end
  endtask
  // test-logic-reset must reload the ident instruction
  task t_ident;
  begin
    u_scan_host_model.tap_reset;
    chk("idle enable", 1'h1, tdo_en_n);
    chk("float", 1'h0, float_outputs);
    u_scan_host_model.shift(1'h0, 33, 400'h1, qv);
    chk("ident", {T_VER, T_PART, T_VEN, 1'h1}, qv[31:0]);
    chk("ident length", 1'h1, qv[32]);
    $display("test ident done");
  end
  endtask
  // every code: pin control, and one-bit path for the bypass-like ones
  task t_codes;
    int c;
  begin
    for (c = 0; c < 16; c++)
    begin
      ir(c[3:0]);
      chk("float", c == 6, float_outputs);
      chk("drive", c == 0 || c == 5, bsr_drive);
      if (!(c inside {0, 1, 2, 3, 7, 8}))
      begin
        u_scan_host_model.shift(1'h0, 9, 400'h1A5, qv);
        chk("bypass", 9'h14A, qv[8:0]);
      end
    end
    $display("test codes done");
  end
  endtask
  // capture, length and update of the boundary ring for both codes
  task t_boundary(input logic [3:0] code, input logic [7:0] pin, input logic [7:0] fill);
  begin
    pin_ring = {49{pin}};
    ir(code);
    u_scan_host_model.shift(1'h0, 393, {7'h0, {49{fill}}, 1'h1}, qv);
    chk("ring capture", {49{pin}}, qv[391:0]);
    chk("ring length", 1'h1, qv[392]);
    chk("ring hold", {49{fill}}, bsr_hold_r);
    $display("test boundary done");
  end
  endtask
  // mode default, reserved write refused, register length
  task t_mode;
  begin
    ir(`OP_MODE_SCAN);
    u_scan_host_model.shift(1'h0, 2, 400'h1, qv);
    chk("mode reset", 2'h0, qv[1:0]);
    u_scan_host_model.shift(1'h0, 2, 400'h2, qv);
    chk("mode debug", 2'h1, qv[1:0]);
    u_scan_host_model.shift(1'h0, 2, 400'h0, qv);
    chk("mode refused", 2'h1, qv[1:0]);
    u_scan_host_model.shift(1'h0, 3, 400'h1, qv);
    chk("mode length", 3'h4, qv[2:0]);
    ir(`OP_RESULT_SCAN);
    u_scan_host_model.shift(1'h0, 26, 400'h1, qv);
    chk("result clean", 26'h2000000, qv[25:0]);
    $display("test mode done");
  end
  endtask
  // go/no-go run with one failing compare, then restart through the packet path
  task t_bist;
    logic q;
    int i;
  begin
    ir(`OP_RUN_BIST);
    u_scan_host_model.tick(1'h0, 1'h0, q);
    for (i = 0; i < 200; i++)
    begin
      repeat (3) @(negedge mclk);
      self_test_clock = 1'h1;
      cmp_valid = (i == 100);
      cmp_fail = (i == 100) ? 72'h1 : 72'h0;
      @(negedge mclk);
      cmp_valid = 1'h0;
      repeat (2) @(negedge mclk);
      self_test_clock = 1'h0;
    end
    repeat (4) @(negedge mclk);
    chk("fill state", `ST_MOVI_ZEROS, bist_state);
    chk("fill addr", 1'h1, bist_addr >= 16'h00C4 && bist_addr <= 16'h00C8);
    chk("fill writer", 2'h0, bist_writer);
    ir(`OP_RESULT_SCAN);
    u_scan_host_model.shift(1'h0, 25, 400'h0, qv);
    chk("result", 25'h3, qv[24:0]);
    ir(`OP_RUN_BIST);
    u_scan_host_model.shift(1'h0, 101, 400'h1, qv);
    chk("packet length", 1'h1, qv[100]);
    chk("restart addr", 16'h0000, bist_addr);
    $display("test bist done");
  end
  endtask
  initial
  begin
    sys_rst = 1'h1;
    self_test_clock = 1'h0;
    cmp_valid = 1'h0;
    cmp_fail = 72'h0;
    pin_ring = 392'h0;
    mismatches = 0;
    n_checks = 0;
    cycles = 0;
    repeat (16) @(negedge mclk);
    sys_rst = 1'h0;
    t_ident;
    t_codes;
    t_ident;
    t_boundary(`OP_EXTEST, 8'h3C, 8'hC3);
    t_boundary(`OP_SAMPLE, 8'h5A, 8'h96);
    t_mode;
    t_bist;
    end_sim;
  end
endmodule // test_jtag_tap_mbist_controller
